/* dma_access_pkg.sv */
// Constants shared by the DMA bus-access configuration block
`default_nettype none
package dma_access_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CFG_OFFSET = 8'h00;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WR_MASK = 32'h01a6_ff00;
   localparam int WR_INVAL_BIT = 24;
   localparam int READ_LINE_BIT = 23;
   localparam int READ_MULT_BIT = 21;
   localparam int POLL_LO = 17;
   localparam int ALIGN_LO = 14;
   localparam int BURST_LO = 8;
   localparam int BURST_W = 6;
   // ----------------------------------------
   // Field codes
   // ----------------------------------------
   localparam logic [1:0] POLL_OFF = 2'h0;
   localparam logic [1:0] POLL_200 = 2'h1;
   localparam logic [1:0] POLL_800 = 2'h2;
   localparam logic [1:0] ALIGN_NONE = 2'h0;
   localparam logic [1:0] ALIGN_8 = 2'h1;
   localparam logic [1:0] ALIGN_16 = 2'h2;
   localparam logic [5:0] WORDS_8 = 6'h08;
   localparam logic [5:0] WORDS_16 = 6'h10;
   localparam logic [5:0] WORDS_32 = 6'h20;
   localparam logic [5:0] BURST_UNLIMITED = 6'h00;
   // ----------------------------------------
   // PCI memory commands
   // ----------------------------------------
   localparam logic [3:0] CMD_MEM_READ = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [3:0] CMD_READ_MULT = 4'hc;
   localparam logic [3:0] CMD_READ_LINE = 4'he;
   localparam logic [3:0] CMD_WR_INVAL = 4'hf;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int POLL_A_US = 200;
   localparam int POLL_B_US = 800;
   localparam int POLL_C_US = 1600;
   localparam int POLL_A_CYC = POLL_A_US * 1000 / CLK_PERIOD_NS;
   localparam int POLL_B_CYC = POLL_B_US * 1000 / CLK_PERIOD_NS;
   localparam int POLL_C_CYC = POLL_C_US * 1000 / CLK_PERIOD_NS;
   localparam int POLL_CNT_W = 18;
endpackage
`default_nettype wire

/* poll_timer.sv */
// Periodic tick generator for transmit descriptor auto-polling
`timescale 1ns/1ns
`default_nettype none
module poll_timer
#(
   parameter int PERIOD_A = dma_access_pkg::POLL_A_CYC,
   parameter int PERIOD_B = dma_access_pkg::POLL_B_CYC,
   parameter int PERIOD_C = dma_access_pkg::POLL_C_CYC
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic [1:0] sel_in,
   output logic tick_out
);
   localparam int W = dma_access_pkg::POLL_CNT_W;
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;
   logic [W-1:0] period;

   if (PERIOD_A < 1 || PERIOD_B < 1 || PERIOD_C < 1 || PERIOD_A >= (1 << W)
      || PERIOD_B >= (1 << W) || PERIOD_C >= (1 << W))
   begin
      $error("poll_timer: period out of range");
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_comb
   begin
      case (sel_in)
         dma_access_pkg::POLL_200: period = W'(PERIOD_A);
         dma_access_pkg::POLL_800: period = W'(PERIOD_B);
         default: period = W'(PERIOD_C);
      endcase
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      // Stopping clears the count so each suspension starts a full period
      if (!run_in || sel_in == dma_access_pkg::POLL_OFF)
         nxt_cnt = '0;
      else if (cnt_ff >= period - W'(1))
      begin
         nxt_cnt = '0;
         nxt_tick = 1'b1;
      end
      else
         nxt_cnt = cnt_ff + W'(1);
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_out = tick_ff;
endmodule
`default_nettype wire

/* dma_access_ctrl.sv */
// DMA bus-access configuration register, command selection and transmit auto-poll
//
// Behaviour
// R1: Write-invalidate enabled: full cache-line writes use Memory Write and Invalidate.
// R2: Write-invalidate disabled: all writes use plain Memory Write.
// R3: Read-line enabled: reads ending on a line boundary use Memory Read Line, unless R4 selects Read Multiple.
// R4: Read-multiple enabled: full aligned line reads use Read Multiple, else Memory Read Line (R3) or plain read.
// R5: Suspended transmitter polls ownership every 200, 800 or 1600 us, or never.
// R6: Alignment field sets burst boundary of 8, 16 or 32 words; zero reserved.
// R7: Burst length field caps words per transaction; zero means unlimited.
// R8: Reset clears polling, command enables and alignment field.
// R9: Software stops transmit and receive before writing the configuration register.
// R10: Each poll reads the descriptor; if owned, transmission restarts.
// R11: Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module dma_access_ctrl
#(
   parameter int POLL_A_CYC = dma_access_pkg::POLL_A_CYC,
   parameter int POLL_B_CYC = dma_access_pkg::POLL_B_CYC,
   parameter int POLL_C_CYC = dma_access_pkg::POLL_C_CYC,
   parameter int LEN_W = 12
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [31:0] req_addr_in,
   input wire logic [LEN_W-1:0] req_words_in,
   output logic cmd_valid_out,
   output logic [3:0] cmd_out,
   output logic [LEN_W-1:0] burst_words_out,
   input wire logic tx_suspended_in,
   output logic poll_read_out,
   input wire logic desc_valid_in,
   input wire logic desc_owned_in,
   output logic tx_restart_out
);
   typedef enum logic [0:0] {POLL_IDLE, POLL_WAIT} poll_state_e;

   logic [31:0] cfg_ff;
   logic [31:0] nxt_cfg;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic cmd_valid_ff;
   logic nxt_cmd_valid;
   logic [3:0] cmd_ff;
   logic [3:0] nxt_cmd;
   logic [LEN_W-1:0] burst_ff;
   logic [LEN_W-1:0] nxt_burst;
   poll_state_e poll_state_ff;
   poll_state_e nxt_poll_state;
   logic poll_read_ff;
   logic nxt_poll_read;
   logic restart_ff;
   logic nxt_restart;
   logic poll_tick;
   logic wr_inval_en;
   logic read_line_en;
   logic read_mult_en;
   logic [1:0] poll_sel;
   logic [1:0] align_sel;
   logic [5:0] burst_cap;
   logic [5:0] line_words;
   logic [5:0] line_offset;
   logic [5:0] to_boundary;
   logic [LEN_W-1:0] granted;
   logic reaches_boundary;
   logic full_line;

   // A 32-word line must fit in the burst count
   if (LEN_W < 7)
   begin
      $error("dma_access_ctrl: LEN_W must hold a 32-word burst");
   end

   assign wr_inval_en = cfg_ff[dma_access_pkg::WR_INVAL_BIT];
   assign read_line_en = cfg_ff[dma_access_pkg::READ_LINE_BIT];
   assign read_mult_en = cfg_ff[dma_access_pkg::READ_MULT_BIT];
   assign poll_sel = cfg_ff[dma_access_pkg::POLL_LO +: 2];
   assign align_sel = cfg_ff[dma_access_pkg::ALIGN_LO +: 2];
   assign burst_cap = cfg_ff[dma_access_pkg::BURST_LO +: dma_access_pkg::BURST_W];

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   always_comb
   begin
      nxt_cfg = cfg_ff;
      nxt_rdata = '0;
      // Software must quiesce both DMA directions before this write
      if (reg_wr_in && reg_addr_in == dma_access_pkg::CFG_OFFSET)
         nxt_cfg = reg_wdata_in & dma_access_pkg::CFG_WR_MASK; // R11
      if (reg_rd_in && reg_addr_in == dma_access_pkg::CFG_OFFSET)
         nxt_rdata = cfg_ff;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cfg_ff <= dma_access_pkg::CFG_RESET; // R8
         rdata_ff <= '0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Burst sizing and command choice
   // ----------------------------------------
   always_comb
   begin
      case (align_sel) // R6
         dma_access_pkg::ALIGN_8: line_words = dma_access_pkg::WORDS_8;
         dma_access_pkg::ALIGN_16: line_words = dma_access_pkg::WORDS_16;
         default: line_words = dma_access_pkg::WORDS_32;
      endcase
      line_offset = req_addr_in[7:2] & (line_words - 6'h01);
      to_boundary = line_words - line_offset;
      granted = req_words_in;
      if (burst_cap != dma_access_pkg::BURST_UNLIMITED && granted > LEN_W'(burst_cap))
         granted = LEN_W'(burst_cap); // R7
      // Reserved alignment code leaves bursts unbounded by any line
      if (align_sel != dma_access_pkg::ALIGN_NONE && granted > LEN_W'(to_boundary))
         granted = LEN_W'(to_boundary); // R6
      reaches_boundary = align_sel != dma_access_pkg::ALIGN_NONE
         && granted == LEN_W'(to_boundary);
      full_line = reaches_boundary && line_offset == 6'h00;
      nxt_cmd_valid = req_valid_in;
      nxt_burst = req_valid_in ? granted : burst_ff;
      nxt_cmd = cmd_ff;
      if (req_valid_in)
      begin
         if (req_write_in)
            nxt_cmd = (wr_inval_en && full_line) ? dma_access_pkg::CMD_WR_INVAL // R1
               : dma_access_pkg::CMD_MEM_WRITE; // R2
         else if (read_mult_en && full_line)
            nxt_cmd = dma_access_pkg::CMD_READ_MULT; // R4
         else if (read_line_en && reaches_boundary)
            nxt_cmd = dma_access_pkg::CMD_READ_LINE; // R3
         else
            nxt_cmd = dma_access_pkg::CMD_MEM_READ;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cmd_valid_ff <= 1'b0;
         cmd_ff <= dma_access_pkg::CMD_MEM_READ;
         burst_ff <= '0;
      end
      else
      begin
         cmd_valid_ff <= nxt_cmd_valid;
         cmd_ff <= nxt_cmd;
         burst_ff <= nxt_burst;
      end
   end

   // ----------------------------------------
   // Transmit auto-poll
   // ----------------------------------------
   poll_timer #(
      .PERIOD_A(POLL_A_CYC),
      .PERIOD_B(POLL_B_CYC),
      .PERIOD_C(POLL_C_CYC)
   ) u_poll_timer (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .run_in(tx_suspended_in && poll_state_ff == POLL_IDLE), // R5
      .sel_in(poll_sel),
      .tick_out(poll_tick)
   );

   always_comb
   begin
      nxt_poll_state = poll_state_ff;
      nxt_poll_read = 1'b0;
      nxt_restart = 1'b0;
      case (poll_state_ff)
         POLL_IDLE:
            if (poll_tick && tx_suspended_in && poll_sel != dma_access_pkg::POLL_OFF)
            begin
               nxt_poll_read = 1'b1; // R10
               nxt_poll_state = POLL_WAIT;
            end
         POLL_WAIT:
            if (desc_valid_in)
            begin
               nxt_restart = desc_owned_in; // R10
               nxt_poll_state = POLL_IDLE;
            end
         default: nxt_poll_state = POLL_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         poll_state_ff <= POLL_IDLE;
         poll_read_ff <= 1'b0;
         restart_ff <= 1'b0;
      end
      else
      begin
         poll_state_ff <= nxt_poll_state;
         poll_read_ff <= nxt_poll_read;
         restart_ff <= nxt_restart;
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign cmd_valid_out = cmd_valid_ff;
   assign cmd_out = cmd_ff;
   assign burst_words_out = burst_ff;
   assign poll_read_out = poll_read_ff;
   assign tx_restart_out = restart_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_wr_inval;
      @(posedge clk_in) disable iff (rst_in)
      req_valid_in && req_write_in && wr_inval_en && full_line |=> cmd_out == 4'hf;
   endproperty
   a_wr_inval: assert property (p_wr_inval) else $error("full line write not invalidate"); // R1

   property p_plain_write;
      @(posedge clk_in) disable iff (rst_in)
      req_valid_in && req_write_in && !wr_inval_en |=> cmd_valid_out && cmd_out == 4'h7;
   endproperty
   a_plain_write: assert property (p_plain_write) else $error("write not plain"); // R2

   property p_read_line;
      @(posedge clk_in) disable iff (rst_in)
      req_valid_in && !req_write_in && read_line_en && reaches_boundary
         && !(read_mult_en && full_line) |=> cmd_out == 4'he;
   endproperty
   a_read_line: assert property (p_read_line) else $error("read line not used"); // R3

   property p_read_mult;
      @(posedge clk_in) disable iff (rst_in)
      req_valid_in && !req_write_in && read_mult_en && !read_line_en
         |=> cmd_out == ($past(full_line) ? 4'hc : 4'h6);
   endproperty
   a_read_mult: assert property (p_read_mult) else $error("read multiple choice wrong"); // R4

   property p_poll_gate;
      @(posedge clk_in) disable iff (rst_in)
      poll_read_out |-> $past(tx_suspended_in) && $past(poll_sel) != 2'h0;
   endproperty
   a_poll_gate: assert property (p_poll_gate) else $error("poll while not enabled"); // R5

   property p_align;
      @(posedge clk_in) disable iff (rst_in)
      req_valid_in && align_sel != 2'h0 |=> burst_words_out <= LEN_W'($past(to_boundary));
   endproperty
   a_align: assert property (p_align) else $error("burst crosses boundary"); // R6

   property p_burst_cap;
      @(posedge clk_in) disable iff (rst_in)
      req_valid_in && burst_cap != 6'h00 |=> burst_words_out <= LEN_W'($past(burst_cap));
   endproperty
   a_burst_cap: assert property (p_burst_cap) else $error("burst exceeds cap"); // R7

   property p_reset_cfg;
      @(posedge clk_in) disable iff (rst_in)
      $past(rst_in) |-> cfg_ff == 32'h0000_0000;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("config not cleared"); // R8

   property p_restart;
      @(posedge clk_in) disable iff (rst_in)
      poll_state_ff == POLL_WAIT && desc_valid_in && desc_owned_in
         |=> tx_restart_out;
   endproperty
   a_restart: assert property (p_restart) else $error("owned descriptor not restarted"); // R10

   property p_reserved;
      @(posedge clk_in) disable iff (rst_in)
      reg_wr_in && reg_addr_in == 8'h00 |=> (cfg_ff & ~32'h01a6_ff00) == 32'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit stored"); // R11
endmodule
`default_nettype wire

/* desc_mem_model.sv */
// Host memory model that answers transmit descriptor polls
`timescale 1ns/1ns
`default_nettype none
module desc_mem_model
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic poll_read_in,
   input wire logic owned_in,
   input wire logic [3:0] delay_in,
   output logic desc_valid_out,
   output logic desc_owned_out
);
   // ----------------------------------------
   // Read latency and reply
   // ----------------------------------------
   // Ownership is only meaningful with the valid pulse; it toggles
   // otherwise so a late sample in the design reads garbage
   logic [4:0] wait_ff;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wait_ff <= 5'h00;
         desc_valid_out <= 1'b0;
         desc_owned_out <= 1'b0;
      end
      else
      begin
         desc_valid_out <= (wait_ff == 5'h01);
         desc_owned_out <= (wait_ff == 5'h01) ? owned_in : ~desc_owned_out;
         if (poll_read_in)
            wait_ff <= {1'b0, delay_in} + 5'h01;
         else if (wait_ff != 5'h00)
            wait_ff <= wait_ff - 5'h01;
      end
   end
endmodule
`default_nettype wire

/* dma_access_ctrl_tb_top.sv */
// Self-checking bench for the DMA bus-access configuration block
`timescale 1ns/1ns
`default_nettype none
module dma_access_ctrl_tb_top;
   localparam int PA = 20;
   localparam int PB = 80;
   localparam int PC = 160;
   logic clk_in, rst_in, reg_wr, reg_rd, req_valid, req_write, tx_susp;
   logic poll_rd, desc_valid, desc_owned, restart, owned, cmd_valid;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, rdata, req_addr;
   logic [11:0] req_words, burst;
   logic [3:0] cmd, delay;
   int error_cnt = 0;
   int n_checks = 0;

   dma_access_ctrl #(.POLL_A_CYC(PA), .POLL_B_CYC(PB), .POLL_C_CYC(PC)) dma_access_ctrl_i
   (
      .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
      .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
      .req_words_in(req_words), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
      .burst_words_out(burst), .tx_suspended_in(tx_susp), .poll_read_out(poll_rd),
      .desc_valid_in(desc_valid), .desc_owned_in(desc_owned), .tx_restart_out(restart)
   );

   desc_mem_model desc_mem_model_i
   (
      .clk_in(clk_in), .rst_in(rst_in), .poll_read_in(poll_rd), .owned_in(owned),
      .delay_in(delay), .desc_valid_out(desc_valid), .desc_owned_out(desc_owned)
   );

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Transmit is not suspended and no DMA runs while the register is written
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_in);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      @(negedge clk_in);
      chk("rdata", exp, rdata);
      @(negedge clk_in);
      chk("rdata idle", 32'h0, rdata);
   endtask

   task automatic dma_req(input logic [31:0] cfg, input logic wr, input logic [31:0] a,
                          input logic [11:0] n, input logic [3:0] ec, input logic [11:0] eb);
      reg_write(8'h00, cfg);
      @(posedge clk_in);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_words <= n;
      @(posedge clk_in);
      req_valid <= 1'b0;
      @(negedge clk_in);
      chk("cmd_valid", 32'h1, {31'h0, cmd_valid});
      chk("cmd", {28'h0, ec}, {28'h0, cmd});
      chk("burst", {20'h0, eb}, {20'h0, burst});
      @(negedge clk_in);
      chk("cmd_valid end", 32'h0, {31'h0, cmd_valid});
   endtask

   // Poll period is accepted within a few cycles of pipeline slack
   task automatic poll_run(input logic [1:0] f, input logic s, input int per,
                           input logic own, input logic [3:0] dl);
      int cnt;
      logic hit;
      reg_write(8'h00, {13'h0, f, 17'h0});
      @(posedge clk_in);
      tx_susp <= s;
      owned <= own;
      delay <= dl;
      cnt = 0;
      while (poll_rd !== 1'b1 && cnt < 400)
      begin
         @(negedge clk_in);
         cnt++;
      end
      if (f == 2'h0 || !s)
         chk("no poll", 32'h1, {31'h0, cnt == 400});
      else if (cnt == 400)
      begin
         error_cnt++;
         $display("[FAIL] poll wait expected %0d seen none", per);
         end_of_test();
      end
      else
      begin
         chk("poll period", 32'h1, {31'h0, cnt >= per && cnt <= per + 3});
         hit = 1'b0;
         repeat (20)
         begin
            @(negedge clk_in);
            hit = hit | (restart === 1'b1);
         end
         chk("restart", {31'h0, own}, {31'h0, hit});
      end
      @(posedge clk_in);
      tx_susp <= 1'b0;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   initial
   begin
      rst_in = 1'b1;
      {reg_wr, reg_rd, req_valid, req_write, tx_susp, owned} = 6'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      req_addr = 32'h0;
      req_words = 12'h000;
      delay = 4'h0;
      repeat (4) @(posedge clk_in);
      chk("cmd in reset", 32'h6, {28'h0, cmd});
      rst_in <= 1'b0;
      reg_read(8'h00, 32'h0);
      reg_write(8'h00, 32'hffff_ffff);
      reg_read(8'h00, 32'h01a6_ff00);
      reg_write(8'h04, 32'h0);
      reg_read(8'h04, 32'h0);
      reg_read(8'h00, 32'h01a6_ff00);
      @(posedge clk_in);
      rst_in <= 1'b1;
      @(posedge clk_in);
      rst_in <= 1'b0;
      reg_read(8'h00, 32'h0);
      $display("Test registers done");
      dma_req(32'h0100_c000, 1'b1, 32'h0, 12'h020, 4'hf, 12'h020);
      dma_req(32'h0000_c000, 1'b1, 32'h0, 12'h020, 4'h7, 12'h020);
      dma_req(32'h0100_c000, 1'b1, 32'h4, 12'h028, 4'h7, 12'h01f);
      dma_req(32'h0100_0000, 1'b1, 32'h0, 12'h020, 4'h7, 12'h020);
      dma_req(32'h0080_4000, 1'b0, 32'h10, 12'h014, 4'he, 12'h004);
      dma_req(32'h0080_4000, 1'b0, 32'h0, 12'h003, 4'h6, 12'h003);
      dma_req(32'h0020_8000, 1'b0, 32'h0, 12'h028, 4'hc, 12'h010);
      dma_req(32'h0020_8000, 1'b0, 32'h8, 12'h028, 4'h6, 12'h00e);
      dma_req(32'h00a0_8000, 1'b0, 32'h8, 12'h028, 4'he, 12'h00e);
      dma_req(32'h0000_e000, 1'b1, 32'h20, 12'h064, 4'h7, 12'h018);
      dma_req(32'h0000_0000, 1'b1, 32'h0, 12'h064, 4'h7, 12'h064);
      for (int i = 0; i < 6; i++)
         dma_req(32'h0000_0100 << i, 1'b0, 32'h0, 12'h064, 4'h6, 12'h001 << i);
      $display("Test commands done");
      poll_run(2'h0, 1'b1, 0, 1'b1, 4'h0);
      poll_run(2'h1, 1'b0, PA, 1'b1, 4'h0);
      poll_run(2'h1, 1'b1, PA, 1'b1, 4'h0);
      poll_run(2'h2, 1'b1, PB, 1'b0, 4'h5);
      poll_run(2'h3, 1'b1, PC, 1'b1, 4'h9);
      $display("Test polling done");
      end_of_test();
   end
endmodule
`default_nettype wire
